// ---- rtl/ufc_frame_ctrl.sv ----
// character format control of an asynchronous serial transceiver
// assumes a single 10 MHz clock, strobe register port, rx from a pin
//
// Operation
// - frames carry 9 data bits when length select is 1, else 8
// - ninth bit received goes to rx ninth field; tx ninth field is sent
// - with parity on, received parity never reaches data or ninth field
// - parity generated and checked only while parity enable is set
// - type 00 gives even parity, 01 gives odd parity
// - type 10 sends constant 1, type 11 constant 0 in parity slot
// - break: finish buffered data, then low at least 13 bits, until cleared
// - with break clear the line carries normal frames
// - rx ninth field is read-only and meaningful in 9-bit format only
// - tx ninth field is write-only and used in 9-bit format only
// - transmitter always appends two stop bits
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ufc_frame_ctrl #(
   parameter int DIV_W = ufc_pkg::DIV_W,
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [ufc_pkg::ADDR_W-1:0] addr,
   input wire logic [ufc_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [ufc_pkg::DATA_W-1:0] rdata_q,
   // serial line
   output logic tx_q,
   input wire logic rx_in
);
   ufc_pkg::ufc_ctrl_t ctrl_q;
   ufc_pkg::ufc_ctrl_t ctrl_wval;
   logic [DIV_W-1:0] div_q;
   logic sel_ctrl, sel_data, sel_stat, sel_div;
   logic wr_ctrl, wr_data, wr_div, rd_ctrl, rd_data, rd_stat;
   logic [7:0] rd_val;
   logic [7:0] stat_val;
   // buffer
   ufc_pkg::ufc_word_t push_word;
   ufc_pkg::ufc_word_t buf_word;
   logic buf_in_ready, buf_out_valid, tx_load;
   // transmitter
   ufc_pkg::ufc_tx_state_t tx_st_q, tx_st_d;
   logic [8:0] tx_sh_q, tx_sh_d, tx_raw, tx_frame;
   logic [3:0] tx_idx_q, tx_idx_d, tx_last, brk_q, brk_d;
   logic stop_q, stop_d, tx_d, tx_par, tx_tick;
   // receiver
   ufc_pkg::ufc_rx_state_t rx_st_q, rx_st_d;
   logic [8:0] rx_sh_q, rx_sh_d;
   logic [3:0] rx_idx_q, rx_idx_d;
   logic rx_s1_q, rx_s2_q, rx_prev_q, rx_tick, rx_done;
   logic rx_par_exp, rx_par_got, perr_evt, ferr_evt;
   logic [7:0] rx_byte, rx_data_q;
   logic rx_ninth_q, rx_valid_q, perr_q, ferr_q, ovr_q;

   // address decode
   assign sel_ctrl = (addr == ufc_pkg::OFS_CTRL);
   assign sel_data = (addr == ufc_pkg::OFS_DATA);
   assign sel_stat = (addr == ufc_pkg::OFS_STAT);
   assign sel_div = (addr == ufc_pkg::OFS_DIV);
   assign wr_ctrl = wr && sel_ctrl;
   assign wr_data = wr && sel_data;
   assign wr_div = wr && sel_div;
   assign rd_ctrl = rd && sel_ctrl;
   assign rd_data = rd && sel_data;
   assign rd_stat = rd && sel_stat;

   // rx ninth bit position is ignored on write
   assign ctrl_wval = '{dls: wdata[ufc_pkg::B_DLS],
                        pen: wdata[ufc_pkg::B_PEN],
                        ptype: wdata[ufc_pkg::B_PT_HI:ufc_pkg::B_PT_LO],
                        brk: wdata[ufc_pkg::B_BRK],
                        tx9: wdata[ufc_pkg::B_TX9]};

   assign stat_val = {2'h0, ovr_q, ferr_q, perr_q, rx_valid_q,
                      (tx_st_q == ufc_pkg::TX_IDLE) && !buf_out_valid,
                      !buf_in_ready};

   // read mux; tx ninth field reads as zero
   always_comb begin
      rd_val = 8'h00;
      if (sel_ctrl) begin
         rd_val = {1'h0, ctrl_q.dls, ctrl_q.pen, ctrl_q.ptype, ctrl_q.brk,
                   rx_ninth_q, 1'h0};
      end else if (sel_data) begin
         rd_val = rx_data_q;
      end else if (sel_stat) begin
         rd_val = stat_val;
      end else if (sel_div) begin
         rd_val = 8'(div_q);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q <= '0;
         div_q <= DIV_W'(ufc_pkg::DIV_RESET);
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= wr_ctrl ? ctrl_wval : ctrl_q;
         div_q <= wr_div ? DIV_W'(wdata) : div_q;
         rdata_q <= rd ? rd_val : 8'h00;
      end
   end

   // tx ninth field travels with each buffered word
   assign push_word = '{ninth: ctrl_q.tx9, data: wdata};

   ufc_fifo2 #(.W($bits(ufc_pkg::ufc_word_t)), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(clk),
      .reset(reset),
      .in_valid(wr_data),
      .in_ready(buf_in_ready),
      .in_data(push_word),
      .out_valid(buf_out_valid),
      .out_ready(tx_load),
      .out_data(buf_word)
   );

   ufc_bit_timer #(.W(DIV_W)) u_tx_tmr (
      .clk(clk),
      .reset(reset),
      .restart(tx_st_q == ufc_pkg::TX_IDLE),
      .half(1'h0),
      .period(div_q),
      .tick(tx_tick)
   );

   ufc_bit_timer #(.W(DIV_W)) u_rx_tmr (
      .clk(clk),
      .reset(reset),
      .restart(rx_st_q == ufc_pkg::RX_IDLE),
      .half(1'h1),
      .period(div_q),
      .tick(rx_tick)
   );

   // transmit frame build
   assign tx_last = ctrl_q.dls ? ufc_pkg::LAST9 : ufc_pkg::LAST8;
   assign tx_load = (tx_st_q == ufc_pkg::TX_IDLE) && buf_out_valid;
   assign tx_raw = {buf_word.ninth, buf_word.data};
   assign tx_par = ufc_pkg::ufc_parity(ctrl_q.ptype, tx_raw,
                                       ctrl_q.dls);
   assign tx_frame = {(ctrl_q.pen && ctrl_q.dls) ? tx_par : tx_raw[8],
                      (ctrl_q.pen && !ctrl_q.dls) ? tx_par : tx_raw[7],
                      tx_raw[6:0]};

   always_comb begin
      tx_st_d = tx_st_q;
      tx_sh_d = tx_sh_q;
      tx_idx_d = tx_idx_q;
      stop_d = stop_q;
      brk_d = brk_q;
      case (tx_st_q)
         ufc_pkg::TX_IDLE: begin
            if (buf_out_valid) begin
               tx_st_d = ufc_pkg::TX_START;
               tx_sh_d = tx_frame;
            end else if (ctrl_q.brk) begin
               tx_st_d = ufc_pkg::TX_BREAK;
               brk_d = 4'h0;
            end
         end
         ufc_pkg::TX_START: begin
            if (tx_tick) begin
               tx_st_d = ufc_pkg::TX_DATA;
               tx_idx_d = 4'h0;
            end
         end
         ufc_pkg::TX_DATA: begin
            if (tx_tick && tx_idx_q == tx_last) begin
               tx_st_d = ufc_pkg::TX_STOP;
               stop_d = 1'h0;
            end else if (tx_tick) begin
               tx_sh_d = {1'h0, tx_sh_q[8:1]};
               tx_idx_d = tx_idx_q + 4'h1;
            end
         end
         ufc_pkg::TX_STOP: begin
            if (tx_tick && stop_q == ufc_pkg::STOP_LAST) begin
               tx_st_d = ufc_pkg::TX_IDLE;
            end else if (tx_tick) begin
               stop_d = ufc_pkg::STOP_LAST;
            end
         end
         ufc_pkg::TX_BREAK: begin
            if (tx_tick && brk_q != ufc_pkg::BRK_BITS) begin
               brk_d = brk_q + 4'h1;
            end
            if (brk_q == ufc_pkg::BRK_BITS && !ctrl_q.brk) begin
               tx_st_d = ufc_pkg::TX_IDLE;
            end
         end
         default: begin
            tx_st_d = ufc_pkg::TX_IDLE;
         end
      endcase
   end

   // line level follows the next state, so tx_q lines up with tx_st_q
   assign tx_d = (tx_st_d == ufc_pkg::TX_DATA) ? tx_sh_d[0] :
                 !(tx_st_d == ufc_pkg::TX_START ||
                   tx_st_d == ufc_pkg::TX_BREAK);

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_st_q <= ufc_pkg::TX_IDLE;
         tx_sh_q <= 9'h000;
         tx_idx_q <= 4'h0;
         stop_q <= 1'h0;
         brk_q <= 4'h0;
         tx_q <= 1'h1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_sh_q <= tx_sh_d;
         tx_idx_q <= tx_idx_d;
         stop_q <= stop_d;
         brk_q <= brk_d;
         tx_q <= tx_d;
      end
   end

   // receiver
   always_comb begin
      rx_st_d = rx_st_q;
      rx_sh_d = rx_sh_q;
      rx_idx_d = rx_idx_q;
      rx_done = 1'h0;
      case (rx_st_q)
         ufc_pkg::RX_IDLE: begin
            if (!rx_s2_q && rx_prev_q) begin
               rx_st_d = ufc_pkg::RX_START;
            end
         end
         ufc_pkg::RX_START: begin
            if (rx_tick) begin
               rx_st_d = rx_s2_q ? ufc_pkg::RX_IDLE : ufc_pkg::RX_DATA;
               rx_idx_d = 4'h0;
            end
         end
         ufc_pkg::RX_DATA: begin
            if (rx_tick) begin
               rx_sh_d[rx_idx_q] = rx_s2_q;
               if (rx_idx_q == tx_last) begin
                  rx_st_d = ufc_pkg::RX_STOP;
               end else begin
                  rx_idx_d = rx_idx_q + 4'h1;
               end
            end
         end
         ufc_pkg::RX_STOP: begin
            if (rx_tick) begin
               rx_st_d = ufc_pkg::RX_IDLE;
               rx_done = 1'h1;
            end
         end
         default: begin
            rx_st_d = ufc_pkg::RX_IDLE;
         end
      endcase
   end

   assign rx_par_exp = ufc_pkg::ufc_parity(ctrl_q.ptype, rx_sh_q,
                                           ctrl_q.dls);
   assign rx_par_got = ctrl_q.dls ? rx_sh_q[8] : rx_sh_q[7];
   assign perr_evt = rx_done && ctrl_q.pen &&
                     (rx_par_exp != rx_par_got);
   assign ferr_evt = rx_done && !rx_s2_q;
   assign rx_byte = {(ctrl_q.pen && !ctrl_q.dls) ? 1'h0 : rx_sh_q[7],
                     rx_sh_q[6:0]};

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_s1_q <= 1'h1;
         rx_s2_q <= 1'h1;
         rx_prev_q <= 1'h1;
         rx_st_q <= ufc_pkg::RX_IDLE;
         rx_sh_q <= 9'h000;
         rx_idx_q <= 4'h0;
      end else begin
         rx_s1_q <= rx_in;
         rx_s2_q <= rx_s1_q;
         rx_prev_q <= rx_s2_q;
         rx_st_q <= rx_st_d;
         rx_sh_q <= rx_sh_d;
         rx_idx_q <= rx_idx_d;
      end
   end

   // received word and sticky flags; a new event wins over a clear
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_data_q <= 8'h00;
         rx_ninth_q <= 1'h0;
         rx_valid_q <= 1'h0;
         perr_q <= 1'h0;
         ferr_q <= 1'h0;
         ovr_q <= 1'h0;
      end else begin
         rx_data_q <= rx_done ? rx_byte : rx_data_q;
         if (rx_done && ctrl_q.dls) begin
            rx_ninth_q <= !ctrl_q.pen && rx_sh_q[8];
         end
         rx_valid_q <= rx_done || (rx_valid_q && !rd_data);
         perr_q <= perr_evt || (perr_q && !rd_stat);
         ferr_q <= ferr_evt || (ferr_q && !rd_stat);
         ovr_q <= (rx_done && rx_valid_q) || (ovr_q && !rd_stat);
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_tx_len;
      (tx_st_q == ufc_pkg::TX_DATA) |-> (tx_idx_q <= tx_last);
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("tx bit count");

   property p_tx_ninth;
      (tx_load && ctrl_q.dls && !ctrl_q.pen) |=>
         (tx_sh_q[8] == $past(buf_word.ninth));
   endproperty
   a_tx_ninth: assert property (p_tx_ninth) else $error("tx ninth");

   property p_rx_ninth;
      (rx_done && ctrl_q.dls && !ctrl_q.pen) |=>
         (rx_ninth_q == $past(rx_sh_q[8]));
   endproperty
   a_rx_ninth: assert property (p_rx_ninth) else $error("rx ninth");

   property p_par_strip;
      (rx_done && ctrl_q.pen) |=>
         ($past(ctrl_q.dls) ? !rx_ninth_q : !rx_data_q[7]);
   endproperty
   a_par_strip: assert property (p_par_strip) else $error("par kept");

   property p_no_perr;
      (!ctrl_q.pen && !perr_q) |=> !perr_q;
   endproperty
   a_no_perr: assert property (p_no_perr) else $error("parity off");

   property p_even_odd;
      (tx_load && ctrl_q.pen && !ctrl_q.ptype[1]) |=>
         ((ctrl_q.dls ? ^tx_sh_q[8:0] : ^tx_sh_q[7:0]) ==
          $past(ctrl_q.ptype[0]));
   endproperty
   a_even_odd: assert property (p_even_odd) else $error("parity");

   property p_mark_space;
      (tx_load && ctrl_q.pen && ctrl_q.ptype[1]) |=>
         ((ctrl_q.dls ? tx_sh_q[8] : tx_sh_q[7]) == !$past(ctrl_q.ptype[0]));
   endproperty
   a_mark_space: assert property (p_mark_space) else $error("mark");

   property p_brk_low;
      (tx_st_q == ufc_pkg::TX_BREAK) |-> !tx_q;
   endproperty
   a_brk_low: assert property (p_brk_low) else $error("break high");

   property p_brk_min;
      (tx_st_q == ufc_pkg::TX_BREAK && brk_q != ufc_pkg::BRK_BITS) |=>
         (tx_st_q == ufc_pkg::TX_BREAK);
   endproperty
   a_brk_min: assert property (p_brk_min) else $error("break short");

   property p_data_first;
      (tx_st_q == ufc_pkg::TX_IDLE && buf_out_valid) |=>
         (tx_st_q == ufc_pkg::TX_START);
   endproperty
   a_data_first: assert property (p_data_first) else $error("order");

   property p_idle_high;
      (tx_st_q == ufc_pkg::TX_IDLE || tx_st_q == ufc_pkg::TX_STOP) |-> tx_q;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line low");

   property p_rx9_ro;
      (wr_ctrl && !rx_done) |=> $stable(rx_ninth_q);
   endproperty
   a_rx9_ro: assert property (p_rx9_ro) else $error("rx9 written");

   property p_tx9_wo;
      rd_ctrl |=> !rdata_q[ufc_pkg::B_TX9];
   endproperty
   a_tx9_wo: assert property (p_tx9_wo) else $error("tx9 read");

   property p_stop2;
      (tx_st_q == ufc_pkg::TX_STOP && tx_tick && !stop_q) |=>
         (tx_st_q == ufc_pkg::TX_STOP) && tx_q;
   endproperty
   a_stop2: assert property (p_stop2) else $error("one stop");

   c_break: cover property (tx_st_q == ufc_pkg::TX_BREAK &&
                            brk_q == ufc_pkg::BRK_BITS);
   c_nine: cover property (rx_done && ctrl_q.dls);
   c_perr: cover property (perr_evt);
   c_full: cover property (!buf_in_ready && wr_data);
endmodule

// ---- rtl/ufc_pkg.sv ----
// shared constants, types and the parity function of the frame control
// assumes a 10 MHz clock and an 8-bit register port
package ufc_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int DIV_W = 8;
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_HZ = 115_200;
   // bit period in clock cycles, minus one
   localparam logic [7:0] DIV_RESET = 8'((CLK_HZ / BAUD_HZ) - 1);
   // register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_DATA = 4'h1;
   localparam logic [3:0] OFS_STAT = 4'h2;
   localparam logic [3:0] OFS_DIV = 4'h3;
   // frame control fields
   localparam int B_DLS = 6;
   localparam int B_PEN = 5;
   localparam int B_PT_HI = 4;
   localparam int B_PT_LO = 3;
   localparam int B_BRK = 2;
   localparam int B_RX9 = 1;
   localparam int B_TX9 = 0;
   // status fields
   localparam int S_FULL = 0;
   localparam int S_TIDLE = 1;
   localparam int S_RXV = 2;
   localparam int S_PERR = 3;
   localparam int S_FERR = 4;
   localparam int S_OVR = 5;
   // parity types
   localparam logic [1:0] PT_EVEN = 2'h0;
   localparam logic [1:0] PT_ODD = 2'h1;
   localparam logic [1:0] PT_MARK = 2'h2;
   localparam logic [1:0] PT_SPACE = 2'h3;
   // frame counts
   localparam logic [3:0] LAST8 = 4'h7;
   localparam logic [3:0] LAST9 = 4'h8;
   localparam logic [3:0] BRK_BITS = 4'hD;
   localparam logic STOP_LAST = 1'h1;

   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } ufc_word_t;

   typedef struct packed {
      logic dls;
      logic pen;
      logic [1:0] ptype;
      logic brk;
      logic tx9;
   } ufc_ctrl_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_START = 3'h1,
      TX_DATA = 3'h3,
      TX_STOP = 3'h2,
      TX_BREAK = 3'h6
   } ufc_tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_START = 2'h1,
      RX_DATA = 2'h3,
      RX_STOP = 2'h2
   } ufc_rx_state_t;

   // parity over the bits that precede the parity slot
   function automatic logic ufc_parity(input logic [1:0] pt,
                                       input logic [8:0] v,
                                       input logic nine);
      logic ones;
      ones = nine ? ^v[7:0] : ^v[6:0];
      if (pt == PT_EVEN) begin
         ufc_parity = ones;
      end else if (pt == PT_ODD) begin
         ufc_parity = ~ones;
      end else begin
         ufc_parity = (pt == PT_MARK);
      end
   endfunction
endpackage

// ---- rtl/ufc_bit_timer.sv ----
// bit period timer: one tick per period+1 cycles
// assumes restart is held while the owner is idle
`timescale 1ns/1ps
module ufc_bit_timer #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic restart,
   input wire logic half,
   input wire logic [W-1:0] period,
   // tick out
   output logic tick
);
   logic [W-1:0] cnt_q;

   assign tick = !restart && (cnt_q == period);

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (restart) begin
         cnt_q <= half ? (period >> 1) : '0;
      end else if (tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'h1;
      end
   end
endmodule

// ---- rtl/ufc_fifo2.sv ----
// small word buffer with valid and ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module ufc_fifo2 #(
   parameter int W = 9,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= push ? wr_q + 1'h1 : wr_q;
         rd_q <= pop ? rd_q + 1'h1 : rd_q;
         cnt_q <= cnt_q + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop};
      end
   end
endmodule

// ---- testbench/ufc_remote_peer.sv ----
// far-side serial transceiver: decodes frames on the line, sends frames
// assumes idle-high lines and a fixed bit period of BIT clocks
`timescale 1ns/1ps
module ufc_remote_peer #(
   parameter int BIT = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial lines
   input wire logic line_in,
   input wire logic [3:0] n_bits,
   output logic line_out
);
   logic [9:0] frames_q[$];
   int low_run;
   int low_max;

   initial line_out = 1'b1;

   // longest run of low line cycles
   always @(posedge clk) begin
      if (reset || line_in) begin
         low_run = 0;
      end else begin
         low_run++;
         if (low_run > low_max) begin
            low_max = low_run;
         end
      end
   end

   // capture {stop bits ok, word}, sampled mid-bit
   initial begin : cap
      logic [8:0] w;
      logic ok;
      low_max = 0;
      forever begin
         @(posedge clk);
         if (!reset && !line_in) begin
            repeat (BIT / 2) @(posedge clk);
            w = '0;
            for (int i = 0; i < int'(n_bits); i++) begin
               repeat (BIT) @(posedge clk);
               w[i] = line_in;
            end
            ok = 1'b1;
            repeat (2) begin
               repeat (BIT) @(posedge clk);
               ok = ok & line_in;
            end
            frames_q.push_back({ok, w});
            while (!line_in) @(posedge clk);
         end
      end
   end

   // send start, n bits lsb first, two stop bits
   task automatic send(input logic [8:0] w, input int n);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         line_out <= w[i];
         repeat (BIT) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (2 * BIT) @(posedge clk);
   endtask
endmodule

// ---- testbench/tb_uart_character_format_control.sv ----
// self-checking bench of the character format control
// assumes divisor 3 (4 clocks per bit) and the peer model on the line
`timescale 1ns/1ps
module tb_uart_character_format_control;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata_q;
   logic tx_q;
   logic rx_in;
   logic [3:0] n_bits = 4'h8;
   int mismatches = 0;
   int cmp_count = 0;
   logic [9:0] exp_q[$];

   always #50 clk = ~clk;

   ufc_frame_ctrl #(.DIV_W(8), .BUF_DEPTH(2)) dut (.clk(clk), .reset(reset),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
      .tx_q(tx_q), .rx_in(rx_in));

   ufc_remote_peer #(.BIT(4)) peer (.clk(clk), .reset(reset),
      .line_in(tx_q), .n_bits(n_bits), .line_out(rx_in));

   task automatic check(input string name, input logic [9:0] seen,
                        input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata_q;
   endtask

   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (peer.frames_q.size() < n && k < 1000) begin
         @(posedge clk);
         k++;
      end
      check("frame_count", 10'(peer.frames_q.size()), 10'(n));
   endtask

   task automatic cmp_frames();
      while (exp_q.size() > 0 && peer.frames_q.size() > 0) begin
         check("tx_frame", peer.frames_q.pop_front(), exp_q.pop_front());
      end
   endtask

   // expected line word: {stop ok, up to 9 bits lsb first}
   function automatic logic [9:0] tx_word(input logic dls, input logic pen,
                                          input logic [1:0] pt,
                                          input logic [8:0] d);
      logic [8:0] w;
      logic p;
      w = dls ? d : {1'b0, d[7:0]};
      p = dls ? ^d[7:0] : ^d[6:0];
      if (pt == 2'h1) p = ~p;
      if (pt == 2'h2) p = 1'b1;
      if (pt == 2'h3) p = 1'b0;
      if (pen && dls) w[8] = p;
      if (pen && !dls) w[7] = p;
      return {1'b1, w};
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end

   initial begin : main
      logic [7:0] v;
      logic [7:0] cfg;
      logic [8:0] d;
      logic [7:0] b[4];
      logic dls;
      logic pen;
      logic err;
      logic rx9;
      logic [1:0] pt;
      int k;
      d = 9'($urandom(59));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd_reg(ufc_pkg::OFS_CTRL, v);
      check("ctrl_reset", 10'(v), 10'h000);
      rd_reg(ufc_pkg::OFS_STAT, v);
      check("stat_reset", 10'(v), 10'h002);
      rd_reg(4'h5, v);
      check("unmapped", 10'(v), 10'h000);
      wr_reg(ufc_pkg::OFS_DIV, 8'h03);
      wr_reg(ufc_pkg::OFS_CTRL, 8'hFB);
      rd_reg(ufc_pkg::OFS_CTRL, v);
      check("ctrl_access", 10'(v), 10'h078);
      rx9 = 1'b0;
      for (int i = 0; i < 10; i++) begin
         dls = (i >= 5);
         pen = (i % 5 != 0);
         pt = 2'(i % 5 - 1);
         d = 9'($urandom);
         cfg = {1'b0, dls, pen, pt, 1'b0, 1'b0, d[8]};
         n_bits <= dls ? 4'h9 : 4'h8;
         wr_reg(ufc_pkg::OFS_CTRL, cfg);
         wr_reg(ufc_pkg::OFS_DATA, d[7:0]);
         exp_q.push_back(tx_word(dls, pen, pt, d));
         wait_frames(1);
         cmp_frames();
         d = 9'($urandom);
         peer.send(d, dls ? 9 : 8);
         repeat (4) @(posedge clk);
         err = pen && (pt[1] ? ((dls ? d[8] : d[7]) == pt[0])
                             : ((dls ? ^d : ^d[7:0]) ^ pt[0]));
         rd_reg(ufc_pkg::OFS_STAT, v);
         check("rx_status", 10'(v & 8'h3C), 10'({err, 3'h4}));
         rd_reg(ufc_pkg::OFS_DATA, v);
         check("rx_data", 10'(v), 10'((!dls && pen) ? {1'b0, d[6:0]}
                                                    : d[7:0]));
         if (dls) rx9 = pen ? 1'b0 : d[8];
         rd_reg(ufc_pkg::OFS_CTRL, v);
         check("rx_ninth", 10'(v), 10'({cfg[7:2], rx9, 1'b0}));
      end
      // fill the buffer until a write is dropped, then ask for a break
      n_bits <= 4'h8;
      wr_reg(ufc_pkg::OFS_CTRL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         b[i] = 8'($urandom);
         @(posedge clk);
         addr <= ufc_pkg::OFS_DATA;
         wdata <= b[i];
         wr <= 1'b1;
      end
      @(posedge clk);
      wr <= 1'b0;
      rd_reg(ufc_pkg::OFS_STAT, v);
      check("buffer_full", 10'(v & 8'h01), 10'h001);
      for (int i = 0; i < 3; i++) exp_q.push_back({2'b10, b[i]});
      wr_reg(ufc_pkg::OFS_CTRL, 8'h04);
      peer.low_max = 0;
      wait_frames(4);
      wr_reg(ufc_pkg::OFS_CTRL, 8'h00);
      k = 0;
      while (!tx_q && k < 300) begin
         @(posedge clk);
         k++;
      end
      check("break_end", 10'(tx_q), 10'h001);
      cmp_frames();
      check("break_frame", peer.frames_q.pop_front(), 10'h000);
      check("break_len", 10'(peer.low_max >= 52), 10'h001);
      d = 9'($urandom);
      wr_reg(ufc_pkg::OFS_DATA, d[7:0]);
      exp_q.push_back({2'b10, d[7:0]});
      wait_frames(1);
      cmp_frames();
      test_done();
   end
endmodule
